/* File: pkg/symbol_latency_defs.vh */
// timing constants for the symbol-mode mii latency block
`ifndef SYMBOL_LATENCY_DEFS_VH
`define SYMBOL_LATENCY_DEFS_VH

// ----------------------------------------------------------------
// time base
// ----------------------------------------------------------------
`define BIT_TIME_NS 10
`define CORE_CLK_NS 20

// ----------------------------------------------------------------
// chosen latencies, in bit times
// ----------------------------------------------------------------
`define RX_J_TO_CRS_BT 16
`define RX_T_TO_CRS_OFF_BT 24
`define RX_CRS_TO_RXD_BT 4
`define RX_CRS_TO_DV_BT 8
`define TX_EN_TO_CRS_BT 2
`define TX_EN_TO_CRS_OFF_BT 4
`define TX_EN_TO_LINE_BT 6

// ----------------------------------------------------------------
// latencies in core clock cycles
// ----------------------------------------------------------------
`define BT_TO_CYC(bt) (((bt) * `BIT_TIME_NS) / `CORE_CLK_NS)
`define RX_J_TO_CRS_CYC `BT_TO_CYC(`RX_J_TO_CRS_BT)
`define RX_T_TO_CRS_OFF_CYC `BT_TO_CYC(`RX_T_TO_CRS_OFF_BT)
`define RX_CRS_TO_RXD_CYC `BT_TO_CYC(`RX_CRS_TO_RXD_BT)
`define RX_CRS_TO_DV_CYC `BT_TO_CYC(`RX_CRS_TO_DV_BT)
`define TX_EN_TO_CRS_CYC `BT_TO_CYC(`TX_EN_TO_CRS_BT)
`define TX_EN_TO_CRS_OFF_CYC `BT_TO_CYC(`TX_EN_TO_CRS_OFF_BT)
`define TX_EN_TO_LINE_CYC `BT_TO_CYC(`TX_EN_TO_LINE_BT)

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define SYM_W 5
`define CNT_W 5
`define SYM_RESET 5'h00

`endif

/* File: hdl/latency_pipe.v */
// fixed-depth registered delay line for the transmit path
`default_nettype none

module latency_pipe #(
  parameter WIDTH = 6,
  parameter DEPTH = 3
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // stream
  input wire [WIDTH-1:0] data_i,
  output wire [WIDTH-1:0] data_o
);

  reg [WIDTH-1:0] stage_q [0:DEPTH-1];
  integer i;

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      stage_q[0] <= data_i;
      for (i = 1; i < DEPTH; i = i + 1) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign data_o = stage_q[DEPTH-1];

endmodule // latency_pipe

`default_nettype wire

/* File: hdl/mii_symbol_latency.v */
// symbol-mode mii latency engine: carrier, collision, receive and transmit timing
`default_nettype none
`include "symbol_latency_defs.vh"

module mii_symbol_latency (
  // clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // mode
  input wire symbol_bypass_mode_i,
  // mii link clock from the mac side, sampled as a pin
  input wire mii_clk_i,
  // receive events from the line decoder, core clock domain
  input wire rx_j_start_i,
  input wire rx_t_start_i,
  input wire rx_collide_i,
  input wire [4:0] rx_code_i,
  // mii receive side to the mac
  output wire crs_o,
  output wire col_o,
  output wire rx_dv_o,
  output wire [4:0] rxd_o,
  // mii transmit side from the mac, asynchronous pins
  input wire tx_en_i,
  input wire [4:0] txd_i,
  // twisted pair transmit stream
  output wire twisted_pair_tx_output_valid_o,
  output wire [4:0] twisted_pair_tx_output_o
);

  // ----------------------------------------------------------------
  // receive state encoding
  // ----------------------------------------------------------------
  localparam [3:0] RX_IDLE = 4'h1;
  localparam [3:0] RX_JWAIT = 4'h2;
  localparam [3:0] RX_ACTIVE = 4'h4;
  localparam [3:0] RX_TWAIT = 4'h8;

  // counts are worked out as integers, then cut to the counter width on purpose
  localparam integer J_CRS_N = `RX_J_TO_CRS_CYC - 1;
  localparam integer T_OFF_N = `RX_T_TO_CRS_OFF_CYC - 1;
  localparam integer RXD_N = `RX_CRS_TO_RXD_CYC;
  localparam integer DV_N = `RX_CRS_TO_DV_CYC;
  localparam integer TX_OFF_N = `TX_EN_TO_CRS_OFF_CYC - 1;
  localparam [4:0] J_CRS_CYC = J_CRS_N[4:0];
  localparam [4:0] T_OFF_CYC = T_OFF_N[4:0];
  localparam [4:0] RXD_CYC = RXD_N[4:0];
  localparam [4:0] DV_CYC = DV_N[4:0];
  localparam [4:0] TX_OFF_CYC = TX_OFF_N[4:0];

  // ----------------------------------------------------------------
  // pin synchronisers, three stages each
  // ----------------------------------------------------------------
  reg [2:0] mclk_q;
  reg [2:0] ten_q;
  reg [4:0] txd_s1_q, txd_s2_q, txd_s3_q;
  reg ten_f_q;
  reg mclk_f_q;

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mclk_q <= 3'h0;
      ten_q <= 3'h0;
      txd_s1_q <= `SYM_RESET;
      txd_s2_q <= `SYM_RESET;
      txd_s3_q <= `SYM_RESET;
      ten_f_q <= 1'b0;
      mclk_f_q <= 1'b0;
    end else begin
      mclk_q <= {mclk_q[1:0], mii_clk_i};
      ten_q <= {ten_q[1:0], tx_en_i};
      txd_s1_q <= txd_i;
      txd_s2_q <= txd_s1_q;
      txd_s3_q <= txd_s2_q;
      // a change of enable only counts once two stages agree
      if (ten_q[1] == ten_q[2]) begin
        ten_f_q <= ten_q[2];
      end
      // the link clock level is only taken once the last two stages agree
      if (mclk_q[1] == mclk_q[2]) begin
        mclk_f_q <= mclk_q[2];
      end
    end
  end

  // mac launches on the falling edge so it can sample on the rising one
  wire mclk_rise = mclk_q[2] & mclk_q[1] & ~mclk_f_q;
  wire mclk_fall = ~mclk_q[2] & ~mclk_q[1] & mclk_f_q;

  // ----------------------------------------------------------------
  // receive timing
  // ----------------------------------------------------------------
  reg [3:0] rx_st_q, rx_st_d;
  reg [4:0] rx_cnt_q, rx_cnt_d;
  reg rx_crs_q, rx_crs_d;
  reg coll_q, coll_d;
  reg rxd_en_q, rxd_en_d;
  reg dv_en_q, dv_en_d;

  always @* begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q + 5'h01;
    rx_crs_d = rx_crs_q;
    coll_d = coll_q | rx_collide_i;
    rxd_en_d = rxd_en_q;
    dv_en_d = dv_en_q;
    case (rx_st_q)
      RX_IDLE: begin
        rx_cnt_d = 5'h00;
        coll_d = rx_collide_i;
        if (rx_j_start_i) begin
          rx_st_d = RX_JWAIT;
        end
      end
      RX_JWAIT: begin
        if (rx_cnt_q == J_CRS_CYC) begin
          rx_st_d = RX_ACTIVE;
          rx_crs_d = 1'b1;
          rx_cnt_d = 5'h00;
        end
      end
      RX_ACTIVE: begin
        if (rx_cnt_q == RXD_CYC - 5'h01) begin
          rxd_en_d = 1'b1;
        end
        if (rx_cnt_q == DV_CYC - 5'h01) begin
          dv_en_d = 1'b1;
        end
        if (rx_cnt_q == DV_CYC) begin
          rx_cnt_d = rx_cnt_q;
        end
        if (rx_t_start_i) begin
          rx_st_d = RX_TWAIT;
          rx_cnt_d = 5'h00;
        end
      end
      RX_TWAIT: begin
        if (rx_cnt_q == T_OFF_CYC) begin
          rx_st_d = RX_IDLE;
          rx_crs_d = 1'b0;
          rxd_en_d = 1'b0;
          dv_en_d = 1'b0;
          coll_d = 1'b0;
          rx_cnt_d = 5'h00;
        end
      end
      default: begin
        rx_st_d = RX_IDLE;
        rx_cnt_d = 5'h00;
        rx_crs_d = 1'b0;
        rxd_en_d = 1'b0;
        dv_en_d = 1'b0;
        coll_d = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 5'h00;
      rx_crs_q <= 1'b0;
      coll_q <= 1'b0;
      rxd_en_q <= 1'b0;
      dv_en_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_crs_q <= rx_crs_d;
      coll_q <= coll_d;
      rxd_en_q <= rxd_en_d;
      dv_en_q <= dv_en_d;
    end
  end

  // ----------------------------------------------------------------
  // transmit sampling and carrier echo
  // ----------------------------------------------------------------
  reg ten_smp_q;
  reg [4:0] txd_smp_q;
  reg tx_crs_q;
  reg [4:0] tx_off_q;

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ten_smp_q <= 1'b0;
      txd_smp_q <= `SYM_RESET;
      tx_crs_q <= 1'b0;
      tx_off_q <= 5'h00;
    end else begin
      if (mclk_rise) begin
        ten_smp_q <= ten_f_q;
        txd_smp_q <= txd_s3_q;
      end
      // one cycle after the sample is two bit times
      if (ten_smp_q) begin
        tx_crs_q <= 1'b1;
        tx_off_q <= 5'h00;
      end else if (tx_crs_q) begin
        if (tx_off_q == TX_OFF_CYC) begin
          tx_crs_q <= 1'b0;
        end else begin
          tx_off_q <= tx_off_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // line transmit latency
  // ----------------------------------------------------------------
  wire [5:0] line_w;

  latency_pipe #(
    .WIDTH(6),
    .DEPTH(`TX_EN_TO_LINE_CYC)
  ) u_tx_pipe (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .data_i({ten_smp_q, txd_smp_q}),
    .data_o(line_w)
  );

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  reg crs_q, col_q, rx_dv_q, line_v_q;
  reg [4:0] rxd_q, line_q;

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      crs_q <= 1'b0;
      col_q <= 1'b0;
      rx_dv_q <= 1'b0;
      rxd_q <= `SYM_RESET;
      line_v_q <= 1'b0;
      line_q <= `SYM_RESET;
    end else begin
      crs_q <= rx_crs_d | tx_crs_q;
      col_q <= rx_crs_d & coll_d;
      line_v_q <= line_w[5];
      line_q <= line_w[5] ? line_w[4:0] : `SYM_RESET;
      // symbols change away from the mac sampling edge; 4b mode masks bit 4
      if (mclk_fall | ~rx_crs_d) begin
        rx_dv_q <= dv_en_d;
        rxd_q <= rxd_en_d ? {rx_code_i[4] & symbol_bypass_mode_i, rx_code_i[3:0]}
                          : `SYM_RESET;
      end
    end
  end

  assign crs_o = crs_q;
  assign col_o = col_q;
  assign rx_dv_o = rx_dv_q;
  assign rxd_o = rxd_q;
  assign twisted_pair_tx_output_valid_o = line_v_q;
  assign twisted_pair_tx_output_o = line_q;

endmodule // mii_symbol_latency

`default_nettype wire

/* File: verif/mii_symbol_latency_monitor.sv */
// assertion checker for the symbol-mode mii latency block
`default_nettype none
module mii_symbol_latency_monitor (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // watched pins
  input wire logic mii_clk_i,
  input wire logic rx_j_start_i,
  input wire logic rx_t_start_i,
  input wire logic rx_collide_i,
  input wire logic tx_en_i,
  input wire logic crs_o,
  input wire logic col_o,
  input wire logic rx_dv_o,
  input wire logic [4:0] rxd_o,
  input wire logic twisted_pair_tx_output_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // receive path
  // ----------------------------------------
  chk_j_crs_on: assert property (rx_j_start_i && !crs_o |-> ##[1:10] crs_o)
    else $error("carrier late");
  chk_t_crs_off: assert property (
    rx_t_start_i && crs_o |-> crs_o[*7] ##[1:8] !crs_o) else $error("carrier end off");
  chk_j_col_on: assert property (
    rx_j_start_i && rx_collide_i && !crs_o |-> ##[1:10] col_o) else $error("collision late");
  chk_t_col_off: assert property (
    rx_t_start_i && col_o |-> col_o[*7] ##[1:8] !col_o) else $error("collision end off");
  chk_crs_dv: assert property ($rose(crs_o) && !tx_en_i |-> ##[3:18] rx_dv_o)
    else $error("valid late");
  chk_crs_rxd: assert property ($rose(crs_o) && !tx_en_i |-> ##[1:16] rxd_o != 5'h00)
    else $error("symbols late");
  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  // bounds include the pin synchroniser, since the pin edge is all we can see
  chk_tx_echo: assert property (
    $rose(mii_clk_i) && tx_en_i && !crs_o |-> ##[1:7] crs_o) else $error("echo late");
  chk_echo_off: assert property ($fell(tx_en_i) |-> ##[1:16] !crs_o)
    else $error("echo stays");
  chk_tx_line: assert property (
    $rose(tx_en_i) && !twisted_pair_tx_output_valid_o |->
    !twisted_pair_tx_output_valid_o[*6] ##[1:10] twisted_pair_tx_output_valid_o)
    else $error("line start off");
  cov_collide: cover property (rx_j_start_i && rx_collide_i);
  cov_dv: cover property ($rose(rx_dv_o));
  cov_line: cover property ($rose(twisted_pair_tx_output_valid_o));
endmodule // mii_symbol_latency_monitor

bind mii_symbol_latency mii_symbol_latency_monitor mon (.core_clk_i, .rst_n_i, .mii_clk_i,
  .rx_j_start_i, .rx_t_start_i, .rx_collide_i, .tx_en_i, .crs_o, .col_o, .rx_dv_o, .rxd_o,
  .twisted_pair_tx_output_valid_o);
`default_nettype wire

/* File: verif/mac_model.sv */
// mac-side partner: drives transmit, samples receive on the mii clock
`default_nettype none
module mac_model (
  // link clock and control
  input wire logic mii_clk_i,
  input wire logic send_i,
  input wire logic [4:0] step_i,
  // receive side
  input wire logic rx_dv_i,
  input wire logic [4:0] rxd_i,
  // transmit side and last received symbol
  output var logic tx_en_o,
  output var logic [4:0] txd_o,
  output var logic [4:0] seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tx_en_o = 1'b0;
    txd_o = 5'h00;
    seen_o = 5'h00;
  end
  // change on the fall so tx is settled around each rise; idle data keeps flipping
  always @(negedge mii_clk_i) begin
    tx_en_o <= send_i;
    txd_o <= send_i ? txd_o + step_i : ~txd_o;
  end
  always @(posedge mii_clk_i) begin
    if (rx_dv_i === 1'b1) seen_o <= rxd_i;
  end
endmodule // mac_model
`default_nettype wire

/* File: verif/mii_symbol_latency_tb.sv */
// self-checking bench for the symbol-mode mii latency block
`default_nettype none
`include "symbol_latency_defs.vh"
module mii_symbol_latency_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and model state
  // ----------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mode = 1'b1;
  logic mclk = 1'b0;
  logic j = 1'b0;
  logic t = 1'b0;
  logic coll = 1'b0;
  logic [4:0] code = 5'h00;
  logic send = 1'b0;
  logic [4:0] step = 5'h01;
  wire tx_en, crs, col, dv, lv;
  wire [4:0] txd, rxd, ld, seen;
  int n_errors = 0;
  int compares = 0;
  int n;
  logic [31:0] seed = 32'h2680;
  logic [4:0] q[$];
  logic [4:0] lq = 5'h00;
  logic lvq = 1'b0;
  always #10 core_clk_i = ~core_clk_i;
  always #80 mclk = ~mclk;
  mii_symbol_latency DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .symbol_bypass_mode_i(mode),
    .mii_clk_i(mclk), .rx_j_start_i(j), .rx_t_start_i(t), .rx_collide_i(coll), .rx_code_i(code),
    .crs_o(crs), .col_o(col), .rx_dv_o(dv), .rxd_o(rxd), .tx_en_i(tx_en), .txd_i(txd),
    .twisted_pair_tx_output_valid_o(lv), .twisted_pair_tx_output_o(ld));
  mac_model mac (.mii_clk_i(mclk), .send_i(send), .step_i(step), .rx_dv_i(dv), .rxd_i(rxd),
    .tx_en_o(tx_en), .txd_o(txd), .seen_o(seen));
  function automatic logic [4:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[4:0];
  endfunction
  task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_crs(input logic v);
    while (crs !== v) begin
      @(posedge core_clk_i);
      #1;
      n++;
      if (n > 40) begin
        n_errors++;
        wrap_up();
      end
    end
  endtask
  // ----------------------------------------
  // receive frame; one edge takes each pulse, the output register adds none as it takes the next carrier
  // ----------------------------------------
  task automatic rx_frame(input logic c, input logic m);
    logic [4:0] k;
    k = rnd() | 5'h11;
    @(posedge core_clk_i);
    code <= k;
    coll <= c;
    mode <= m;
    j <= 1'b1;
    t <= c;
    @(posedge core_clk_i);
    j <= 1'b0;
    t <= 1'b0;
    #1;
    n = 1;
    wait_crs(1'b1);
    chk("crs_on", 5'(`RX_J_TO_CRS_CYC + 1), 5'(n));
    chk("col_on", {4'h0, c}, {4'h0, col});
    repeat (40) @(posedge core_clk_i);
    chk("rxd", m ? k : k & 5'h0F, seen);
    chk("dv", 5'h01, {4'h0, dv});
    t <= 1'b1;
    @(posedge core_clk_i);
    t <= 1'b0;
    #1;
    n = 1;
    wait_crs(1'b0);
    chk("crs_off", 5'(`RX_T_TO_CRS_OFF_CYC + 1), 5'(n));
    chk("col_off", 5'h00, {4'h0, col});
    @(posedge core_clk_i);
    coll <= 1'b0;
  endtask
  task automatic tx_frame(input int len);
    @(posedge core_clk_i);
    step <= rnd() | 5'h01;
    send <= 1'b1;
    repeat (len * 8) @(posedge core_clk_i);
    chk("echo", 5'h01, {4'h0, crs});
    send <= 1'b0;
    repeat (24) @(posedge core_clk_i);
    chk("echo_off", 5'h00, {4'h0, crs});
  endtask
  // ----------------------------------------
  // line model: one symbol per sampled enable, in order
  // ----------------------------------------
  always @(posedge mclk) begin
    if (tx_en === 1'b1) q.push_back(txd);
  end
  always @(posedge core_clk_i) begin
    if (lv === 1'b1 && (lvq !== 1'b1 || ld !== lq)) begin
      chk("line", q.size() > 0 ? q.pop_front() : 5'h00, ld);
    end
    lvq <= lv;
    lq <= ld;
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      rx_frame(i[0], !i[0]);
      $display("test rx frame %0d done", i);
    end
    for (int i = 0; i < 3; i++) begin
      tx_frame(3 + rnd() % 8);
      $display("test tx frame %0d done", i);
    end
    repeat (40) @(posedge core_clk_i);
    chk("left", 5'h00, 5'(q.size()));
    wrap_up();
  end
endmodule // mii_symbol_latency_tb
`default_nettype wire
